// *** src/hf_cmd_pkg.sv ***
// Constants for the HF tag byte and head password command interpreter
package hf_cmd_pkg;
    // Command codes
    localparam logic [15:0] CMD_READ_DSFID = 16'h0094;
    localparam logic [15:0] CMD_WRITE_DSFID = 16'h0095;
    localparam logic [15:0] CMD_LOCK_DSFID = 16'h0096;
    localparam logic [15:0] CMD_SET_HEAD_PWD = 16'h0100;
    // Error codes
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_AIR_TIMEOUT = 16'hF102;
    localparam logic [15:0] ERR_MULTI_TAG = 16'hF010;
    localparam logic [15:0] ERR_PWD_MISMATCH = 16'hF011;
    localparam logic [15:0] ERR_FRAG_NONZERO = 16'hF012;
    localparam logic [15:0] ERR_BAD_CMD = 16'hF013;
    localparam logic [15:0] ERR_NO_PWD = 16'hF014;
    // Register byte offsets
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_WDATA = 8'h04;
    localparam logic [7:0] OFS_RESP = 8'h08;
    localparam logic [7:0] OFS_RDATA = 8'h0C;
    localparam logic [7:0] OFS_ERR = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_CFG = 8'h18;
    localparam logic [7:0] OFS_INT_STAT = 8'h1C;
    localparam logic [7:0] OFS_INT_MASK = 8'h20;
    // Field positions
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_FRAG_LSB = 16;
    localparam int CFG_MULTI_TAG_BIT = 0;
    localparam int CFG_UHF_BIT = 1;
    localparam int STAT_TAG_BIT = 0;
    localparam int STAT_PWD_BIT = 1;
    localparam int STAT_AVAIL_LSB = 8;
    localparam int STAT_COUNT_LSB = 16;
    localparam int INT_DONE_BIT = 0;
    localparam int INT_ERR_BIT = 1;
    localparam int INT_BITS = 2;
    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0] RST_CFG = 2'h0;
    localparam logic [7:0] RST_DSFID = 8'h00;
    // Data bytes reported by a successful identifier read
    localparam logic [7:0] AVAIL_DSFID = 8'h01;
endpackage : hf_cmd_pkg

// *** src/hf_tag_byte_and_password_cmds.sv ***
// Command interpreter for HF identifier byte and head password commands
//
// Functional notes
// - Code 0x0094 reads tag identifier byte; echo code, byte in read data byte 0.
// - Code 0x0095 writes write data byte 0 as identifier; echo code, no read data.
// - Code 0x0096 locks identifier byte; echo code, no data used.
// - Writing a locked identifier leaves it unchanged and reports 0xF102.
// - Locking an already locked identifier fails with 0xF102.
// - Code 0x0100 sets head password from write data bytes 0 to 3.
// - Write fragment number is zero in request and response.
// - Set head password ignores tag identifier length, start address, length fields.
// - Head password is volatile; lost when head supply resets.
// - In UHF mode the password lives in interface memory instead.
// - Stored password is attached to every tag read, write and lock access.
// - HF password functions need single-tag mode; multi-tag reports a fault.
// - HF protected access succeeds only if head and tag passwords match.
`timescale 1ns/1ps
module hf_tag_byte_and_password_cmds #(
    parameter int PWD_W = 32
) (
    input wire logic sys_clk_in,              // 100 MHz clock
    input wire logic arst_n_in,               // Async reset, active low
    input wire logic psel_in,                 // APB select
    input wire logic penable_in,              // APB enable
    input wire logic pwrite_in,               // APB direction
    input wire logic [7:0] paddr_in,          // APB byte address
    input wire logic [31:0] pwdata_in,        // APB write data
    input wire logic tag_present_in,          // Tag in field, pin
    input wire logic head_supply_ok_in,       // Head supply good, pin
    input wire logic [PWD_W-1:0] tag_pwd_in,  // Password held by tag, pins
    output logic [31:0] prdata_out,           // APB read data
    output logic pready_out,                  // APB ready
    output logic pslverr_out,                 // APB error
    output logic irq_out,                     // Interrupt level
    output logic air_strobe_out,              // Tag access pulse
    output logic [PWD_W-1:0] air_pwd_out      // Password sent with access
);

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [2+PWD_W-1:0] sync1_reg;
    logic [2+PWD_W-1:0] sync2_reg;
    logic tag_s, supply_s;
    logic [PWD_W-1:0] tag_pwd_s;

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {tag_present_in, head_supply_ok_in, tag_pwd_in};
            sync2_reg <= sync1_reg;
        end
    end

    assign tag_s = sync2_reg[PWD_W+1];
    assign supply_s = sync2_reg[PWD_W];
    assign tag_pwd_s = sync2_reg[PWD_W-1:0];

    ////////////////////////////////////////////////////////////////////
    // APB access decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    logic access, wr_acc, mapped, exec;
    logic [15:0] req_code;
    logic [7:0] req_frag;

    assign access = psel_in && penable_in && pready_out;
    assign wr_acc = access && pwrite_in;
    assign mapped = (paddr_in <= hf_cmd_pkg::OFS_INT_MASK) && (paddr_in[1:0] == 2'h0);
    assign exec = wr_acc && hit(paddr_in, hf_cmd_pkg::OFS_CMD);
    assign req_code = pwdata_in[hf_cmd_pkg::CMD_CODE_LSB +: 16];
    assign req_frag = pwdata_in[hf_cmd_pkg::CMD_FRAG_LSB +: 8];

    ////////////////////////////////////////////////////////////////////
    // State
    logic [31:0] cmd_reg, cmd_next, wdata_reg, wdata_next, prdata_next;
    logic [15:0] resp_reg, resp_next, err_reg, err_next, pwd_err;
    logic [7:0] rdata_reg, rdata_next, avail_reg, avail_next, count_reg, count_next, dsfid_reg, dsfid_next;
    logic [1:0] cfg_reg, cfg_next;
    logic [hf_cmd_pkg::INT_BITS-1:0] istat_reg, istat_next, imask_reg, imask_next;
    logic [PWD_W-1:0] head_pwd_reg, head_pwd_next, if_pwd_reg, if_pwd_next, air_pwd_next, act_pwd;
    logic lock_reg, lock_next, head_pwd_ok_reg, head_pwd_ok_next, if_pwd_ok_reg, if_pwd_ok_next;
    logic pready_next, pslverr_next, irq_next, strobe_next;
    logic multi, uhf, act_pwd_ok, pwd_gate_fail;

    assign multi = cfg_reg[hf_cmd_pkg::CFG_MULTI_TAG_BIT];
    assign uhf = cfg_reg[hf_cmd_pkg::CFG_UHF_BIT];
    // Password source per application type
    assign act_pwd = uhf ? if_pwd_reg : head_pwd_reg;
    assign act_pwd_ok = uhf ? if_pwd_ok_reg : head_pwd_ok_reg;

    ////////////////////////////////////////////////////////////////////
    // Password check applied before any HF-mode tag access; UHF accesses pass unchecked
    always_comb begin
        pwd_gate_fail = 1'b0;
        pwd_err = hf_cmd_pkg::ERR_NONE;
        if (!uhf && act_pwd_ok && multi) begin
            pwd_gate_fail = 1'b1;
            pwd_err = hf_cmd_pkg::ERR_MULTI_TAG;
        end else if (!uhf && (tag_pwd_s != '0) && !act_pwd_ok) begin
            pwd_gate_fail = 1'b1;
            pwd_err = hf_cmd_pkg::ERR_NO_PWD;
        end else if (!uhf && (tag_pwd_s != '0) && (act_pwd != tag_pwd_s)) begin
            pwd_gate_fail = 1'b1;
            pwd_err = hf_cmd_pkg::ERR_PWD_MISMATCH;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Command execution and register next values
    always_comb begin
        cmd_next = cmd_reg;
        wdata_next = wdata_reg;
        resp_next = resp_reg;
        rdata_next = rdata_reg;
        err_next = err_reg;
        avail_next = avail_reg;
        count_next = count_reg;
        cfg_next = cfg_reg;
        imask_next = imask_reg;
        dsfid_next = dsfid_reg;
        lock_next = lock_reg;
        head_pwd_next = head_pwd_reg;
        head_pwd_ok_next = head_pwd_ok_reg;
        if_pwd_next = if_pwd_reg;
        if_pwd_ok_next = if_pwd_ok_reg;
        strobe_next = 1'b0;
        air_pwd_next = air_pwd_out;
        istat_next = istat_reg;
        if (wr_acc && hit(paddr_in, hf_cmd_pkg::OFS_INT_STAT)) begin
            istat_next = istat_reg & ~pwdata_in[hf_cmd_pkg::INT_BITS-1:0];
        end
        if (wr_acc && hit(paddr_in, hf_cmd_pkg::OFS_WDATA)) begin
            wdata_next = pwdata_in;
        end
        if (wr_acc && hit(paddr_in, hf_cmd_pkg::OFS_CFG)) begin
            cfg_next = pwdata_in[1:0];
        end
        if (wr_acc && hit(paddr_in, hf_cmd_pkg::OFS_INT_MASK)) begin
            imask_next = pwdata_in[hf_cmd_pkg::INT_BITS-1:0];
        end
        if (exec) begin
            cmd_next = pwdata_in;
            resp_next = req_code;
            avail_next = '0;
            rdata_next = '0;
            err_next = hf_cmd_pkg::ERR_NONE;
            if (req_frag != 8'h00) begin
                err_next = hf_cmd_pkg::ERR_FRAG_NONZERO;
            end else if (req_code == hf_cmd_pkg::CMD_SET_HEAD_PWD) begin
                // Only the four password bytes are looked at
                if (uhf) begin
                    if_pwd_next = wdata_reg[PWD_W-1:0];
                    if_pwd_ok_next = 1'b1;
                end else if (multi) begin
                    err_next = hf_cmd_pkg::ERR_MULTI_TAG;
                end else begin
                    head_pwd_next = wdata_reg[PWD_W-1:0];
                    head_pwd_ok_next = 1'b1;
                end
            end else if (req_code == hf_cmd_pkg::CMD_READ_DSFID ||
                         req_code == hf_cmd_pkg::CMD_WRITE_DSFID ||
                         req_code == hf_cmd_pkg::CMD_LOCK_DSFID) begin
                if (!tag_s) begin
                    err_next = hf_cmd_pkg::ERR_AIR_TIMEOUT;
                end else if (pwd_gate_fail) begin
                    err_next = pwd_err;
                end else begin
                    strobe_next = 1'b1;
                    air_pwd_next = act_pwd_ok ? act_pwd : '0;
                    if (req_code == hf_cmd_pkg::CMD_READ_DSFID) begin
                        rdata_next = dsfid_reg;
                        avail_next = hf_cmd_pkg::AVAIL_DSFID;
                        count_next = count_reg + 8'h01;
                    end else if (lock_reg) begin
                        err_next = hf_cmd_pkg::ERR_AIR_TIMEOUT;
                    end else if (req_code == hf_cmd_pkg::CMD_WRITE_DSFID) begin
                        dsfid_next = wdata_reg[7:0];
                        count_next = count_reg + 8'h01;
                    end else begin
                        lock_next = 1'b1;
                        count_next = count_reg + 8'h01;
                    end
                end
            end else begin
                err_next = hf_cmd_pkg::ERR_BAD_CMD;
            end
        end
        // Head password is lost with the head supply
        if (!supply_s) begin
            head_pwd_next = '0;
            head_pwd_ok_next = 1'b0;
        end
        // Set wins over a same-cycle clear
        if (exec) begin
            istat_next[hf_cmd_pkg::INT_DONE_BIT] = 1'b1;
            if (err_next != hf_cmd_pkg::ERR_NONE) begin
                istat_next[hf_cmd_pkg::INT_ERR_BIT] = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB slave answer
    always_comb begin
        pready_next = psel_in && penable_in && !pready_out;
        pslverr_next = 1'b0;
        prdata_next = hf_cmd_pkg::RST_WORD;
        if (psel_in && penable_in && !pready_out) begin
            pslverr_next = !mapped;
            if (!pwrite_in) begin
                unique case (paddr_in)
                    hf_cmd_pkg::OFS_CMD: prdata_next = cmd_reg;
                    hf_cmd_pkg::OFS_WDATA: prdata_next = wdata_reg;
                    // Response fragment number is always zero
                    hf_cmd_pkg::OFS_RESP: prdata_next = {16'h0000, resp_reg};
                    hf_cmd_pkg::OFS_RDATA: prdata_next = {24'h000000, rdata_reg};
                    hf_cmd_pkg::OFS_ERR: prdata_next = {16'h0000, err_reg};
                    hf_cmd_pkg::OFS_STATUS: prdata_next = {8'h00, count_reg, avail_reg,
                                                           6'h00, act_pwd_ok, tag_s};
                    hf_cmd_pkg::OFS_CFG: prdata_next = {30'h00000000, cfg_reg};
                    hf_cmd_pkg::OFS_INT_STAT: prdata_next = {30'h00000000, istat_reg};
                    hf_cmd_pkg::OFS_INT_MASK: prdata_next = {30'h00000000, imask_reg};
                    default: prdata_next = hf_cmd_pkg::RST_WORD;
                endcase
            end
        end
        irq_next = |(istat_next & imask_next);
    end

    ////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cmd_reg <= hf_cmd_pkg::RST_WORD;
            wdata_reg <= hf_cmd_pkg::RST_WORD;
            resp_reg <= '0;
            rdata_reg <= '0;
            err_reg <= hf_cmd_pkg::ERR_NONE;
            avail_reg <= '0;
            count_reg <= '0;
            cfg_reg <= hf_cmd_pkg::RST_CFG;
            istat_reg <= '0;
            imask_reg <= '0;
            dsfid_reg <= hf_cmd_pkg::RST_DSFID;
            lock_reg <= 1'b0;
            head_pwd_reg <= '0;
            head_pwd_ok_reg <= 1'b0;
            if_pwd_reg <= '0;
            if_pwd_ok_reg <= 1'b0;
            prdata_out <= hf_cmd_pkg::RST_WORD;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            irq_out <= 1'b0;
            air_strobe_out <= 1'b0;
            air_pwd_out <= '0;
        end else begin
            cmd_reg <= cmd_next;
            wdata_reg <= wdata_next;
            resp_reg <= resp_next;
            rdata_reg <= rdata_next;
            err_reg <= err_next;
            avail_reg <= avail_next;
            count_reg <= count_next;
            cfg_reg <= cfg_next;
            istat_reg <= istat_next;
            imask_reg <= imask_next;
            dsfid_reg <= dsfid_next;
            lock_reg <= lock_next;
            head_pwd_reg <= head_pwd_next;
            head_pwd_ok_reg <= head_pwd_ok_next;
            if_pwd_reg <= if_pwd_next;
            if_pwd_ok_reg <= if_pwd_ok_next;
            prdata_out <= prdata_next;
            pready_out <= pready_next;
            pslverr_out <= pslverr_next;
            irq_out <= irq_next;
            air_strobe_out <= strobe_next;
            air_pwd_out <= air_pwd_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_exec_ok(logic [15:0] c);
        exec && req_code == c && req_frag == 8'h00 && tag_s && !pwd_gate_fail;
    endsequence

    a_read_byte: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        s_exec_ok(hf_cmd_pkg::CMD_READ_DSFID) |=> rdata_reg == $past(dsfid_reg) &&
            resp_reg == hf_cmd_pkg::CMD_READ_DSFID && avail_reg == hf_cmd_pkg::AVAIL_DSFID)
        else $error("identifier read result wrong");
    a_write_byte: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        s_exec_ok(hf_cmd_pkg::CMD_WRITE_DSFID) ##0 !lock_reg |=>
            dsfid_reg == $past(wdata_reg[7:0]) && err_reg == hf_cmd_pkg::ERR_NONE)
        else $error("identifier write not stored");
    a_lock_sets: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        s_exec_ok(hf_cmd_pkg::CMD_LOCK_DSFID) |=> lock_reg ##1 lock_reg)
        else $error("identifier lock not held");
    a_locked_write: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        s_exec_ok(hf_cmd_pkg::CMD_WRITE_DSFID) ##0 lock_reg |=>
            $stable(dsfid_reg) && err_reg == hf_cmd_pkg::ERR_AIR_TIMEOUT)
        else $error("locked identifier changed");
    a_relock_fail: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        s_exec_ok(hf_cmd_pkg::CMD_LOCK_DSFID) ##0 lock_reg |=>
            err_reg == hf_cmd_pkg::ERR_AIR_TIMEOUT)
        else $error("second lock not refused");
    a_head_pwd_set: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        exec && req_code == hf_cmd_pkg::CMD_SET_HEAD_PWD && req_frag == 8'h00 && !uhf && !multi &&
            supply_s |=> head_pwd_reg == $past(wdata_reg[PWD_W-1:0]) && resp_reg == $past(req_code))
        else $error("head password not set");
    a_frag_refused: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        exec && req_frag != 8'h00 |=> err_reg == hf_cmd_pkg::ERR_FRAG_NONZERO && $stable(dsfid_reg))
        else $error("nonzero fragment accepted");
    a_pwd_volatile: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        !supply_s |=> !head_pwd_ok_reg && head_pwd_reg == '0)
        else $error("head password survived supply loss");
    a_multi_fault: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        exec && req_code == hf_cmd_pkg::CMD_SET_HEAD_PWD && req_frag == 8'h00 && !uhf && multi |=>
            err_reg == hf_cmd_pkg::ERR_MULTI_TAG ##1 istat_reg[hf_cmd_pkg::INT_ERR_BIT])
        else $error("multi-tag password fault missing");
    a_pwd_attach: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        air_strobe_out && $past(act_pwd_ok) |-> air_pwd_out == $past(act_pwd))
        else $error("password not attached to access");
    a_pwd_match: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        air_strobe_out && !$past(uhf) && $past(tag_pwd_s) != '0 |-> $past(act_pwd) == $past(tag_pwd_s))
        else $error("access with wrong password");
    a_apb_ready: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        psel_in && penable_in && !pready_out |=> pready_out ##1 !pready_out)
        else $error("APB ready timing wrong");

endmodule : hf_tag_byte_and_password_cmds

// *** verif/hf_tag_model.sv ***
// Behavioural HF tag at the far side of the air strobe
`timescale 1ns/1ps
module hf_tag_model (
    input wire logic sys_clk_in,            // Clock
    input wire logic in_field_in,           // Tag placed in field
    input wire logic [31:0] pwd_stored_in,  // Password held in tag
    input wire logic air_strobe_in,         // Access pulse from block
    input wire logic [31:0] air_pwd_in,     // Password sent with access
    output logic tag_present_out,           // Presence seen by block
    output logic [31:0] tag_pwd_out,        // Tag password seen by block
    output int strobe_count_out,            // Accesses seen
    output int bad_access_out               // Accesses a real tag refuses
);
    assign tag_present_out = in_field_in;
    assign tag_pwd_out = pwd_stored_in;
    always @(posedge sys_clk_in) begin
        if (air_strobe_in === 1'b1) begin
            strobe_count_out <= strobe_count_out + 1;
            if (!in_field_in || (pwd_stored_in != 32'h0000_0000 && air_pwd_in !== pwd_stored_in)) begin
                bad_access_out <= bad_access_out + 1;
            end
        end
    end
endmodule : hf_tag_model

// *** verif/tb_hf_tag_byte_and_password_cmds.sv ***
// Self-checking bench for the HF identifier byte and head password commands
`timescale 1ns/1ps
module tb_hf_tag_byte_and_password_cmds;
    typedef struct {logic [31:0] cmd; logic [31:0] wd; logic [15:0] resp; logic [15:0] err;
        logic [7:0] rdata; logic chk_rd; logic strobe;} row_t;
    logic sys_clk_in = 1'b0, arst_n_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0000_0000, rd, pwd_stored = 32'h0000_0000, air_pwd_out, tag_pwd, prdata_out;
    logic in_field = 1'b1, supply = 1'b1, err, tag_present, pready_out, pslverr_out, irq_out, air_strobe_out;
    logic [7:0] cnt;
    int bad_count = 0, total_checks = 0, cycles = 0, strobes, bad_access, n0;
    row_t rows [8] = '{
        '{32'h0000_0095, 32'h0000_00A5, 16'h0095, 16'h0000, 8'h00, 1'b0, 1'b1},
        '{32'h0000_0094, 32'h0000_0000, 16'h0094, 16'h0000, 8'hA5, 1'b1, 1'b1},
        '{32'h0000_0096, 32'h0000_0000, 16'h0096, 16'h0000, 8'h00, 1'b0, 1'b1},
        '{32'h0000_0095, 32'h0000_003C, 16'h0095, 16'hF102, 8'h00, 1'b0, 1'b1},
        '{32'h0000_0094, 32'h0000_0000, 16'h0094, 16'h0000, 8'hA5, 1'b1, 1'b1},
        '{32'h0000_0096, 32'h0000_0000, 16'h0096, 16'hF102, 8'h00, 1'b0, 1'b1},
        '{32'h0000_0100, 32'h0000_0000, 16'h0100, 16'h0000, 8'h00, 1'b0, 1'b0},
        '{32'h0001_0094, 32'h0000_0000, 16'h0094, 16'hF012, 8'h00, 1'b0, 1'b0}};
    hf_tag_byte_and_password_cmds hf_tag_byte_and_password_cmds_inst (.sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .tag_present_in(tag_present), .head_supply_ok_in(supply),
        .tag_pwd_in(tag_pwd), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .irq_out(irq_out), .air_strobe_out(air_strobe_out), .air_pwd_out(air_pwd_out));
    hf_tag_model hf_tag_model_inst (.sys_clk_in(sys_clk_in), .in_field_in(in_field), .pwd_stored_in(pwd_stored),
        .air_strobe_in(air_strobe_out), .air_pwd_in(air_pwd_out), .tag_present_out(tag_present),
        .tag_pwd_out(tag_pwd), .strobe_count_out(strobes), .bad_access_out(bad_access));
    initial begin
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    // One APB transfer; waits for pready without assuming a latency
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge sys_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge sys_clk_in);
        penable_in <= 1'b1;
        do @(posedge sys_clk_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : xfer
    task automatic cmd_err(input logic [31:0] c, input logic [31:0] d, input logic [15:0] e);
        xfer(hf_cmd_pkg::OFS_WDATA, 1'b1, d);
        xfer(hf_cmd_pkg::OFS_CMD, 1'b1, c);
        xfer(hf_cmd_pkg::OFS_ERR, 1'b0, 32'h0000_0000);
        check(rd, {16'h0000, e});
    endtask : cmd_err
    task automatic settle();
        repeat (3) @(posedge sys_clk_in);
    endtask : settle
    initial begin
        repeat (5) @(posedge sys_clk_in);
        arst_n_in <= 1'b1;
        foreach (rows[i]) begin
            xfer(8'h08 + 8'(4 * (i % 4)), 1'b0, 32'h0000_0000);
            // Status shows the tag already in the field
            check(rd, {31'h0, (i % 4) == 3});
        end
        $display("reset test done");
        foreach (rows[i]) begin
            n0 = strobes;
            cmd_err(rows[i].cmd, rows[i].wd, rows[i].err);
            xfer(hf_cmd_pkg::OFS_RESP, 1'b0, 32'h0000_0000);
            check(rd, {16'h0000, rows[i].resp});
            if (rows[i].chk_rd) begin
                xfer(hf_cmd_pkg::OFS_RDATA, 1'b0, 32'h0000_0000);
                check(rd, {24'h000000, rows[i].rdata});
            end
            check(32'(strobes - n0), {31'h0, rows[i].strobe});
            $display("row %0d done", i);
        end
        pwd_stored <= 32'h1234_5678;
        settle();
        cmd_err(32'h0000_0094, 32'h0000_0000, 16'hF011);
        cmd_err(32'h0000_0100, 32'h1234_5678, 16'h0000);
        xfer(hf_cmd_pkg::OFS_STATUS, 1'b0, 32'h0000_0000);
        cnt = rd[23:16];
        cmd_err(32'h0000_0094, 32'h0000_0000, 16'h0000);
        check(air_pwd_out, 32'h1234_5678);
        xfer(hf_cmd_pkg::OFS_STATUS, 1'b0, 32'h0000_0000);
        check({8'h00, rd[23:8], 6'h00, rd[1:0]}, {8'h00, cnt + 8'h01, 8'h01, 8'h03});
        $display("password test done");
        xfer(hf_cmd_pkg::OFS_CFG, 1'b1, 32'h0000_0001);
        cmd_err(32'h0000_0100, 32'h1234_5678, 16'hF010);
        cmd_err(32'h0000_0094, 32'h0000_0000, 16'hF010);
        xfer(hf_cmd_pkg::OFS_CFG, 1'b1, 32'h0000_0000);
        supply <= 1'b0;
        settle();
        supply <= 1'b1;
        settle();
        cmd_err(32'h0000_0094, 32'h0000_0000, 16'hF014);
        xfer(hf_cmd_pkg::OFS_CFG, 1'b1, 32'h0000_0002);
        cmd_err(32'h0000_0100, 32'h1234_5678, 16'h0000);
        supply <= 1'b0;
        settle();
        supply <= 1'b1;
        settle();
        xfer(hf_cmd_pkg::OFS_STATUS, 1'b0, 32'h0000_0000);
        check({31'h0, rd[1]}, 32'h0000_0001);
        xfer(hf_cmd_pkg::OFS_CFG, 1'b1, 32'h0000_0000);
        in_field <= 1'b0;
        settle();
        cmd_err(32'h0000_0094, 32'h0000_0000, 16'hF102);
        check(32'(bad_access), 32'h0000_0000);
        $display("mode test done");
        @(posedge sys_clk_in);
        check({31'h0, irq_out}, 32'h0000_0000);
        xfer(hf_cmd_pkg::OFS_INT_MASK, 1'b1, 32'h0000_0003);
        @(posedge sys_clk_in);
        check({31'h0, irq_out}, 32'h0000_0001);
        xfer(hf_cmd_pkg::OFS_INT_STAT, 1'b1, 32'h0000_0003);
        @(posedge sys_clk_in);
        check({31'h0, irq_out}, 32'h0000_0000);
        xfer(8'h24, 1'b0, 32'h0000_0000);
        check({rd[30:0], err}, 32'h0000_0001);
        xfer(8'h02, 1'b1, 32'hFFFF_FFFF);
        check({31'h0, err}, 32'h0000_0001);
        $display("interrupt and bus test done");
        // Mid-run reset must unlock and clear the identifier byte
        arst_n_in <= 1'b0;
        pwd_stored <= 32'h0000_0000;
        in_field <= 1'b1;
        repeat (5) @(posedge sys_clk_in);
        arst_n_in <= 1'b1;
        cmd_err(32'h0000_0096, 32'h0000_0000, 16'h0000);
        cmd_err(32'h0000_0094, 32'h0000_0000, 16'h0000);
        xfer(hf_cmd_pkg::OFS_RDATA, 1'b0, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        $display("mid-run reset test done");
        complete_run();
    end
endmodule : tb_hf_tag_byte_and_password_cmds
